// *** common/capw_pkg.sv ***
// Types shared by the counter array files.
// Assumes capw_regs.svh holds the numeric constants.
package capw_pkg;

   typedef enum logic [2:0] {
      CAPW_TB_DIV12 = 3'h0,
      CAPW_TB_DIV4  = 3'h1,
      CAPW_TB_T0OVF = 3'h2,
      CAPW_TB_ECI   = 3'h3,
      CAPW_TB_SYS   = 3'h4,
      CAPW_TB_EXT8  = 3'h5,
      CAPW_TB_RSV6  = 3'h6,
      CAPW_TB_RSV7  = 3'h7
   } capw_tbsel_t;

endpackage : capw_pkg

// *** common/capw_regs.svh ***
// Register map, field positions, reset values and divider counts
// of the counter array. Assumes an 8-bit special function register
// bus with byte addresses.
`ifndef CAPW_REGS_SVH
`define CAPW_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CAPW_A_CTRL 8'hD8
`define CAPW_A_MODE 8'hD9
`define CAPW_A_CPM0 8'hDA
`define CAPW_A_CPM1 8'hDB
`define CAPW_A_CPM2 8'hDC
`define CAPW_A_CNTL 8'hF9
`define CAPW_A_CNTH 8'hFA
`define CAPW_A_CPL0 8'hFB
`define CAPW_A_CPH0 8'hFC
`define CAPW_A_CPL1 8'hE9
`define CAPW_A_CPH1 8'hEA
`define CAPW_A_CPL2 8'hEB
`define CAPW_A_CPH2 8'hEC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAPW_C_CF    7
`define CAPW_C_CR    6
`define CAPW_C_WDF   2
`define CAPW_M_IDLE_SUSPEND  7
`define CAPW_M_WATCHDOG_ENABLE  6
`define CAPW_M_WATCHDOG_LOCK 5
`define CAPW_M_TBHI  3
`define CAPW_M_TBLO  1
`define CAPW_M_ECF   0
`define CAPW_P_W16   7
`define CAPW_P_ECOM  6
`define CAPW_P_MAT   3
`define CAPW_P_PWM   1
`define CAPW_P_ECCF  0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CAPW_RST_CTRL 8'h00
`define CAPW_RST_MODE 8'h40
`define CAPW_SWT_MODE 8'h48
`define CAPW_DIV12    4'hB
`define CAPW_DIV4     2'h3
`define CAPW_EXT_DIV  3'h7

`endif

// *** src/capw_chan.sv ***
// One capture/compare module: compare match and PWM output pin.
// Assumes cnt_i is the counter before the step marked by tick_i.
`timescale 1ns/1ps
`default_nettype none
`include "capw_regs.svh"

module capw_chan (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        tick_i,
   input  wire logic [15:0] cnt_i,
   input  wire logic [7:0]  mode_i,
   input  wire logic [7:0]  cpl_i,
   input  wire logic [7:0]  cph_i,
   output logic             match_o,
   output logic             pwm8_o,
   output logic             pin_o
);

   logic [15:0] cnt_nxt;
   logic        ovf8;
   logic        ovf16;
   logic        pwm;
   logic [7:0]  cpl_eff;

   assign cnt_nxt = cnt_i + 16'h0001;
   assign ovf8    = tick_i && (cnt_i[7:0] == 8'hFF);
   assign ovf16   = tick_i && (cnt_i == 16'hFFFF);
   assign pwm     = mode_i[`CAPW_P_PWM];
   assign pwm8_o  = pwm && !mode_i[`CAPW_P_W16];
   // Reload lands at the low overflow, so compare against it then
   assign cpl_eff = ovf8 ? cph_i : cpl_i;

   always_comb begin
      if (pwm8_o) begin
         match_o = tick_i && (cnt_nxt[7:0] == cpl_eff);
      end else begin
         match_o = tick_i && (cnt_nxt == {cph_i, cpl_i});
      end
   end

   // Set beats reset, so a zero compare gives full duty
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_o <= 1'b0;
      end else if (!mode_i[`CAPW_P_ECOM] || !pwm) begin
         pin_o <= 1'b0;
      end else if (match_o) begin
         pin_o <= 1'b1;
      end else if (pwm8_o ? ovf8 : ovf16) begin
         pin_o <= 1'b0;
      end
   end

endmodule : capw_chan
`default_nettype wire

// *** src/capw_core.sv ***
// Counter array with three compare modules and the module 2 watchdog.
// Assumes a same-clock register bus: one-cycle write strobe, and a
// read strobe whose data appear on the next edge.
//
// How it works
// - 8-bit PWM: high byte 0 gives full duty, 0xFF least; no ECOM, 0%.
// - 16-bit PWM pin rises on compare match, falls on counter overflow.
// - ECOM, PWM and wide bit together select 16-bit PWM.
// - 16-bit compare 0 is full duty, 0xFFFF least; no ECOM holds 0%.
// - Low byte write clears ECOM, high byte write sets it.
// - Watchdog on: module 2 high byte watches counter high byte.
// - Watchdog enable resets to one.
// - Watchdog on: counter runs, counter, timebase, idle, module 2 locked.
// - Watchdog on: counter ignores run bit writes, run bit reads as written.
// - Watchdog on: high byte write loads counter high plus offset.
// - Watchdog on: reset request when low byte overflows while high bytes match.
// - Watchdog on: writing one to module 2 flag requests reset.
// - Enable or lock turns watchdog on; lock holds until reset.
// - Mode register ignores all writes while enable bit is one.
// - Timeout is 256 times offset plus 256 minus low byte.
// - Reset defaults: divide by 12, counter and offset zero.
// - Overflow flag sets on 0xFFFF wrap, software clears it.
// - Module flag sets on match, software clears it.
// - Run bit starts and stops counter.
// - Idle suspend pauses the array while processor idles.
// - Timebase select picks one of six sources, two reserved.
// - Mode bit 7 picks 16-bit over 8-bit PWM.
`timescale 1ns/1ps
`default_nettype none
`include "capw_regs.svh"

module capw_core import capw_pkg::*; (
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   input  wire logic       cpu_idle_i,
   input  wire logic       timer0_ovf_i,
   input  wire logic       ext_count_input_i,
   input  wire logic       ext_clk_i,
   output logic      [2:0] module_io_pin_o,
   output logic            irq_o,
   output logic            wdt_reset_o
);

   // ----------------------------------------
   // Address tables
   // ----------------------------------------
   localparam logic [7:0] A_CPM [3] = '{`CAPW_A_CPM0,
                                        `CAPW_A_CPM1,
                                        `CAPW_A_CPM2};
   localparam logic [7:0] A_CPL [3] = '{`CAPW_A_CPL0,
                                        `CAPW_A_CPL1,
                                        `CAPW_A_CPL2};
   localparam logic [7:0] A_CPH [3] = '{`CAPW_A_CPH0,
                                        `CAPW_A_CPH1,
                                        `CAPW_A_CPH2};

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic              overflow_flag_r;
   logic              counter_run_r;
   logic [2:0]        module_event_flag_r;
   logic              idle_suspend_r;
   logic              watchdog_enable_r;
   logic              watchdog_lock_r;
   capw_tbsel_t       timebase_select_r;
   logic              overflow_irq_enable_r;
   logic [7:0]        mode_r [3];
   logic [7:0]        compare_low_byte_r [3];
   logic [7:0]        compare_high_byte_r [3];
   logic [15:0]       cnt_r;

   logic              wdt_on;
   logic              tick;
   logic              step;
   logic              low_ovf;
   logic              wide_ovf;
   logic              wr_ctrl;
   logic              wr_mode;
   logic [2:0]        match;
   logic [2:0]        pwm8;
   logic [7:0]        mode_eff [3];
   logic [7:0]        rd_nxt;

   // ----------------------------------------
   // Run control and timebase
   // ----------------------------------------
   assign wdt_on   = watchdog_enable_r || watchdog_lock_r;
   assign wr_ctrl  = sfr_wr_i && (sfr_addr_i == `CAPW_A_CTRL);
   assign wr_mode  = sfr_wr_i && (sfr_addr_i == `CAPW_A_MODE);
   // Watchdog forces the counter on without touching the run bit
   assign step     = tick && (counter_run_r || wdt_on)
                     && !(idle_suspend_r && cpu_idle_i);
   assign low_ovf  = step && (cnt_r[7:0] == 8'hFF);
   assign wide_ovf = step && (cnt_r == 16'hFFFF);

   capw_timebase u_timebase (
      .core_clk_i        (core_clk_i),
      .rst_n_i           (rst_n_i),
      .sel_i             (timebase_select_r),
      .timer0_ovf_i      (timer0_ovf_i),
      .ext_count_input_i (ext_count_input_i),
      .ext_clk_i         (ext_clk_i),
      .tick_o            (tick)
   );

   // ----------------------------------------
   // Compare modules
   // ----------------------------------------
   always_comb begin
      mode_eff[0] = mode_r[0];
      mode_eff[1] = mode_r[1];
      // Module 2 behaves as a software timer under the watchdog
      mode_eff[2] = wdt_on ? `CAPW_SWT_MODE : mode_r[2];
   end

   for (genvar g = 0; g < 3; g++) begin : g_chan
      capw_chan u_chan (
         .core_clk_i (core_clk_i),
         .rst_n_i    (rst_n_i),
         .tick_i     (step),
         .cnt_i      (cnt_r),
         .mode_i     (mode_eff[g]),
         .cpl_i      (compare_low_byte_r[g]),
         .cph_i      (compare_high_byte_r[g]),
         .match_o    (match[g]),
         .pwm8_o     (pwm8[g]),
         .pin_o      (module_io_pin_o[g])
      );
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 16'h0000;
      end else if (!wdt_on && sfr_wr_i
                   && sfr_addr_i == `CAPW_A_CNTL) begin
         cnt_r[7:0] <= sfr_wdata_i;
      end else if (!wdt_on && sfr_wr_i
                   && sfr_addr_i == `CAPW_A_CNTH) begin
         cnt_r[15:8] <= sfr_wdata_i;
      end else if (step) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // A hardware set in the same cycle as a software clear wins
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_flag_r     <= 1'b0;
         counter_run_r       <= 1'b0;
         module_event_flag_r <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            overflow_flag_r     <= sfr_wdata_i[`CAPW_C_CF] || wide_ovf;
            counter_run_r       <= sfr_wdata_i[`CAPW_C_CR];
         end else if (wide_ovf) begin
            overflow_flag_r     <= 1'b1;
         end
         for (int i = 0; i < 3; i++) begin
            if (match[i] && mode_eff[i][`CAPW_P_MAT]) begin
               module_event_flag_r[i] <= 1'b1;
            end else if (wr_ctrl) begin
               module_event_flag_r[i] <= sfr_wdata_i[i];
            end
         end
      end
   end

   // ----------------------------------------
   // Mode register
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_suspend_r        <= 1'b0;
         watchdog_enable_r     <= 1'b1;
         watchdog_lock_r       <= 1'b0;
         timebase_select_r     <= CAPW_TB_DIV12;
         overflow_irq_enable_r <= 1'b0;
      end else if (wr_mode && !watchdog_enable_r) begin
         if (!wdt_on) begin
            idle_suspend_r    <= sfr_wdata_i[`CAPW_M_IDLE_SUSPEND];
            timebase_select_r <= capw_tbsel_t'(
               sfr_wdata_i[`CAPW_M_TBHI:`CAPW_M_TBLO]);
         end
         watchdog_enable_r     <= sfr_wdata_i[`CAPW_M_WATCHDOG_ENABLE];
         // Lock only ever sets; reset is the sole way out
         watchdog_lock_r       <= watchdog_lock_r
                                  || sfr_wdata_i[`CAPW_M_WATCHDOG_LOCK];
         overflow_irq_enable_r <= sfr_wdata_i[`CAPW_M_ECF];
      end
   end

   // ----------------------------------------
   // Module mode registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 3; i++) begin
            mode_r[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (i == 2 && wdt_on) begin
               mode_r[i] <= mode_r[i];
            end else if (sfr_wr_i && sfr_addr_i == A_CPM[i]) begin
               mode_r[i] <= sfr_wdata_i;
            end else if (sfr_wr_i && sfr_addr_i == A_CPL[i]) begin
               mode_r[i][`CAPW_P_ECOM] <= 1'b0;
            end else if (sfr_wr_i && sfr_addr_i == A_CPH[i]) begin
               mode_r[i][`CAPW_P_ECOM] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Compare registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 3; i++) begin
            compare_low_byte_r[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sfr_wr_i && sfr_addr_i == A_CPL[i]) begin
               compare_low_byte_r[i] <= sfr_wdata_i;
            end else if (pwm8[i] && low_ovf) begin
               compare_low_byte_r[i] <= compare_high_byte_r[i];
            end
         end
      end
   end

   // Under the watchdog the offset counts whole low byte overflows
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 3; i++) begin
            compare_high_byte_r[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sfr_wr_i && sfr_addr_i == A_CPH[i]) begin
               if (i == 2 && wdt_on) begin
                  compare_high_byte_r[i] <= cnt_r[15:8]
                                          + compare_low_byte_r[i];
               end else begin
                  compare_high_byte_r[i] <= sfr_wdata_i;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Watchdog reset and interrupt
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdt_reset_o <= 1'b0;
      end else begin
         wdt_reset_o <= wdt_on
            && ((low_ovf
                 && compare_high_byte_r[2] == cnt_r[15:8])
                || (wr_ctrl && sfr_wdata_i[`CAPW_C_WDF]));
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (overflow_flag_r && overflow_irq_enable_r)
                  || (module_event_flag_r[0] && mode_r[0][`CAPW_P_ECCF])
                  || (module_event_flag_r[1] && mode_r[1][`CAPW_P_ECCF])
                  || (module_event_flag_r[2] && mode_r[2][`CAPW_P_ECCF]);
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      rd_nxt = 8'h00;
      case (sfr_addr_i)
         `CAPW_A_CTRL: rd_nxt = {overflow_flag_r, counter_run_r,
                                 3'h0, module_event_flag_r};
         `CAPW_A_MODE: rd_nxt = {idle_suspend_r, watchdog_enable_r,
                                 watchdog_lock_r, 1'b0,
                                 timebase_select_r,
                                 overflow_irq_enable_r};
         `CAPW_A_CPM0: rd_nxt = mode_r[0];
         `CAPW_A_CPM1: rd_nxt = mode_r[1];
         `CAPW_A_CPM2: rd_nxt = mode_r[2];
         `CAPW_A_CNTL: rd_nxt = cnt_r[7:0];
         `CAPW_A_CNTH: rd_nxt = cnt_r[15:8];
         `CAPW_A_CPL0: rd_nxt = compare_low_byte_r[0];
         `CAPW_A_CPH0: rd_nxt = compare_high_byte_r[0];
         `CAPW_A_CPL1: rd_nxt = compare_low_byte_r[1];
         `CAPW_A_CPH1: rd_nxt = compare_high_byte_r[1];
         `CAPW_A_CPL2: rd_nxt = compare_low_byte_r[2];
         `CAPW_A_CPH2: rd_nxt = compare_high_byte_r[2];
         default:      rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= rd_nxt;
      end
   end

endmodule : capw_core
`default_nettype wire

// *** src/capw_timebase.sv ***
// Counter timebase: one-cycle tick for the selected source.
// Assumes pin inputs are asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "capw_regs.svh"

module capw_timebase import capw_pkg::*; (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire capw_tbsel_t sel_i,
   input  wire logic        timer0_ovf_i,
   input  wire logic        ext_count_input_i,
   input  wire logic        ext_clk_i,
   output logic             tick_o
);

   logic [3:0] div12_r;
   logic [1:0] div4_r;
   logic [2:0] ext_div_r;
   logic [2:0] eci_s_r;
   logic [2:0] ext_s_r;
   logic       tick_nxt;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div12_r <= 4'h0;
         div4_r  <= 2'h0;
      end else begin
         div12_r <= (div12_r == `CAPW_DIV12) ? 4'h0 : div12_r + 4'h1;
         div4_r  <= div4_r + 2'h1;
      end
   end

   // Bit 0 is the first synchroniser stage; only bit 1 reads it
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eci_s_r <= 3'h0;
         ext_s_r <= 3'h0;
      end else begin
         eci_s_r <= {eci_s_r[1:0], ext_count_input_i};
         ext_s_r <= {ext_s_r[1:0], ext_clk_i};
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_div_r <= 3'h0;
      end else if (ext_s_r[1] && !ext_s_r[2]) begin
         ext_div_r <= ext_div_r + 3'h1;
      end
   end

   always_comb begin
      case (sel_i)
         CAPW_TB_DIV12: tick_nxt = (div12_r == `CAPW_DIV12);
         CAPW_TB_DIV4:  tick_nxt = (div4_r == `CAPW_DIV4);
         CAPW_TB_T0OVF: tick_nxt = timer0_ovf_i;
         CAPW_TB_ECI:   tick_nxt = eci_s_r[2] && !eci_s_r[1];
         CAPW_TB_SYS:   tick_nxt = 1'b1;
         CAPW_TB_EXT8:  tick_nxt = ext_s_r[1] && !ext_s_r[2]
                                   && (ext_div_r == `CAPW_EXT_DIV);
         default:       tick_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= tick_nxt;
      end
   end

endmodule : capw_timebase
`default_nettype wire

// *** tb/capw_core_asserts.sv ***
// Checker: bus reads, PWM pins, watchdog pulse.
// Assumes the watchdog stays on throughout.
`timescale 1ns/1ps
`default_nettype none
`include "capw_regs.svh"

module capw_core_asserts (
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_wr_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic [2:0] module_io_pin_o,
   input wire logic       wdt_reset_o
);
   // ----------------------------------------
   // Mirror of written enables
   // ----------------------------------------
   logic [1:0] ecom_r;
   logic [1:0] pwm_r;
   logic       run_r;
   wire  [1:0] on_w    = ecom_r & pwm_r;
   wire  [1:0] en_w    = {sfr_wdata_i[`CAPW_P_ECOM], sfr_wdata_i[`CAPW_P_PWM]};
   wire        rd_ctrl = sfr_rd_i && sfr_addr_i == `CAPW_A_CTRL;
   wire        rd_mode = sfr_rd_i && sfr_addr_i == `CAPW_A_MODE;
   wire        rd_cpm0 = sfr_rd_i && sfr_addr_i == `CAPW_A_CPM0;
   wire        force_w = sfr_wr_i && sfr_addr_i == `CAPW_A_CTRL
                         && sfr_wdata_i[`CAPW_C_WDF];

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ecom_r <= 2'h0;
         pwm_r  <= 2'h0;
         run_r  <= 1'b0;
      end else if (sfr_wr_i) begin
         case (sfr_addr_i)
            `CAPW_A_CTRL: run_r <= sfr_wdata_i[`CAPW_C_CR];
            `CAPW_A_CPM0: {ecom_r[0], pwm_r[0]} <= en_w;
            `CAPW_A_CPM1: {ecom_r[1], pwm_r[1]} <= en_w;
            `CAPW_A_CPL0: ecom_r[0] <= 1'b0;
            `CAPW_A_CPH0: ecom_r[0] <= 1'b1;
            `CAPW_A_CPL1: ecom_r[1] <= 1'b0;
            `CAPW_A_CPH1: ecom_r[1] <= 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_pin0_off: assert property ((!on_w[0]) [*3] |-> !module_io_pin_o[0])
      else $error("pin 0 high with PWM off");
   a_pin1_off: assert property ((!on_w[1]) [*3] |-> !module_io_pin_o[1])
      else $error("pin 1 high with PWM off");
   a_pin2_quiet: assert property (!module_io_pin_o[2])
      else $error("pin 2 high under the watchdog");
   a_force_reset: assert property (force_w |-> ##[1:2] wdt_reset_o)
      else $error("flag write gave no watchdog reset");
   a_wdt_single: assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("watchdog reset too wide");
   a_mode_frozen: assert property (
      rd_mode |-> ##2 sfr_rdata_o == `CAPW_RST_MODE)
      else $error("mode register changed");
   a_run_read: assert property (
      rd_ctrl |-> ##2 sfr_rdata_o[`CAPW_C_CR] == $past(run_r, 2)
                      && sfr_rdata_o[5:3] == 3'h0)
      else $error("run bit reads wrong");
   a_ecom_read: assert property (
      rd_cpm0 |-> ##2 sfr_rdata_o[`CAPW_P_ECOM] == $past(ecom_r[0], 2))
      else $error("compare enable reads wrong");
   a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
      else $error("read data changed unread");

   c_wdt: cover property (wdt_reset_o);
   c_pin0: cover property ($rose(module_io_pin_o[0]));
   c_pin1: cover property ($rose(module_io_pin_o[1]));
endmodule : capw_core_asserts

bind capw_core capw_core_asserts i_capw_core_asserts (.core_clk_i,
   .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
   .sfr_rdata_o, .module_io_pin_o, .wdt_reset_o);
`default_nettype wire

// *** tb/capw_core_tb.sv ***
// Self-checking bench for the counter array top.
// Assumes the processor model is the only bus master.
`timescale 1ns/1ps
`default_nettype none
`include "capw_regs.svh"

module capw_core_tb;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic        cpu_idle_i = 1'b0;
   logic [2:0]  misc_r     = 3'h0;
   logic [7:0]  addr, wdata, rdata, d, h, l;
   logic        wr, rd, wdt;
   logic [2:0]  pin;
   int          fail_count = 0;
   int          check_count = 0;
   int          n;
   logic [39:0] rows [12];
   logic [7:0]  cph [3] = '{8'h00, 8'h80, 8'hFF};
   int          hi [4] = '{3072, 1536, 12, 0};

   always #4 core_clk_i = ~core_clk_i;
   // Pin inputs toggle, but the timebase stays at /12
   always @(posedge core_clk_i) misc_r <= misc_r + 3'h1;

   capw_core i_capw_core (.core_clk_i, .rst_n_i, .sfr_addr_i(addr),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
      .sfr_rdata_o(rdata), .cpu_idle_i, .timer0_ovf_i(&misc_r),
      .ext_count_input_i(misc_r[1]), .ext_clk_i(misc_r[2]),
      .module_io_pin_o(pin), .irq_o(), .wdt_reset_o(wdt));
   capw_cpu_model i_capw_cpu_model (.core_clk_i, .sfr_rdata_i(rdata),
      .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_rd_o(rd),
      .sfr_wdata_o(wdata));

   // ----------------------------------------
   // Checks and helpers
   // ----------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_cnt(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("ERROR %0t: count %0d, not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_cnt

   // Cycles until pin sel (0..2) or watchdog reset (3) is high
   task automatic wait_on(input int lim, input int sel);
      n = 0;
      #1;
      while (n < lim && (sel == 3 ? wdt : pin[sel]) !== 1'b1) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
   endtask : wait_on

   task automatic duty();
      n = 0;
      repeat (3072) begin
         @(posedge core_clk_i);
         #1;
         if (pin[0] === 1'b1) n++;
      end
   endtask : duty

   task automatic do_reset();
      @(posedge core_clk_i) rst_n_i <= 1'b0;
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
   endtask : do_reset

   task automatic give_verdict();
      $display("%0d checks, %0d mismatches", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   initial begin
      #600000;
      fail_count++;
      give_verdict();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      // Write addr, data, read addr, mask, expected
      rows = '{40'h0000D8F800, 40'h0000D9FF40, 40'hD900D9FF40,
               40'hD9BFD9FF40, 40'hFAEEFAFF01, 40'hDA42DAFF42,
               40'hFB10DAFF02, 40'hFC80DAFF42, 40'h00AAFCFF80,
               40'h015501FF00, 40'hD840D87840, 40'hD800D87800};
      do_reset();
      wait_on(3200, 3);
      chk_cnt(n, 3060, 3090);
      $display("default timeout done");
      foreach (rows[i]) begin
         i_capw_cpu_model.wr(rows[i][39:32], rows[i][31:24]);
         i_capw_cpu_model.rd(rows[i][23:16], d);
         chk_byte(d & rows[i][15:8], rows[i][7:0]);
      end
      $display("register table done");
      i_capw_cpu_model.rd(`CAPW_A_CNTH, h);
      i_capw_cpu_model.wr(`CAPW_A_CPL2, 8'h01);
      i_capw_cpu_model.rd(`CAPW_A_CNTL, l);
      i_capw_cpu_model.wr(`CAPW_A_CPH2, 8'hAA);
      wait_on(7000, 3);
      chk_cnt(n, (512 - l) * 12 - 30, (512 - l) * 12 + 30);
      i_capw_cpu_model.rd(`CAPW_A_CPH2, d);
      chk_byte(d, h + 8'h01);
      i_capw_cpu_model.wr(`CAPW_A_CTRL, 8'h04);
      wait_on(4, 3);
      chk_cnt(n, 0, 3);
      $display("watchdog update done");
      // Idle suspend is frozen at zero, so idle must not pause
      @(posedge core_clk_i) cpu_idle_i <= 1'b1;
      i_capw_cpu_model.wr(`CAPW_A_CPM0, 8'h42);
      for (int i = 0; i < 4; i++) begin
         if (i < 3)
            i_capw_cpu_model.wr16(`CAPW_A_CPL0, {cph[i], cph[i]});
         else
            i_capw_cpu_model.wr(`CAPW_A_CPL0, 8'h00);
         repeat (3200) @(posedge core_clk_i);
         duty();
         chk_cnt(n, hi[i], hi[i]);
      end
      $display("8-bit duty done");
      i_capw_cpu_model.wr(`CAPW_A_CPM1, 8'hC2);
      i_capw_cpu_model.rd(`CAPW_A_CNTH, h);
      i_capw_cpu_model.wr16(`CAPW_A_CPL1, {h + 8'h01, 8'h00});
      wait_on(3200, 1);
      i_capw_cpu_model.rd(`CAPW_A_CNTL, l);
      i_capw_cpu_model.rd(`CAPW_A_CNTH, d);
      chk_cnt(l, 0, 1);
      chk_byte(d, h + 8'h01);
      i_capw_cpu_model.wr(`CAPW_A_CPL1, 8'h00);
      repeat (3) @(posedge core_clk_i);
      chk_byte({7'h00, pin[1]}, 8'h00);
      $display("16-bit match done");
      do_reset();
      i_capw_cpu_model.rd(`CAPW_A_MODE, d);
      chk_byte(d, `CAPW_RST_MODE);
      i_capw_cpu_model.rd(`CAPW_A_CTRL, d);
      chk_byte(d, `CAPW_RST_CTRL);
      $display("second reset done");
      give_verdict();
   end
endmodule : capw_core_tb
`default_nettype wire

// *** tb/capw_cpu_model.sv ***
// Processor side of the register bus, one access at a time.
// Assumes the block samples strobes on the rising edge.
`timescale 1ns/1ps
`default_nettype none

module capw_cpu_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] sfr_rdata_i,
   output logic      [7:0] sfr_addr_o,
   output logic            sfr_wr_o,
   output logic            sfr_rd_o,
   output logic      [7:0] sfr_wdata_o
);
   initial {sfr_addr_o, sfr_wr_o, sfr_rd_o, sfr_wdata_o} = 18'h00000;

   // Released lines show the inverse, so a stale value never matches
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      sfr_addr_o  <= a;
      sfr_wdata_o <= d;
      sfr_wr_o    <= 1'b1;
      @(posedge core_clk_i);
      sfr_wr_o    <= 1'b0;
      sfr_addr_o  <= ~a;
      sfr_wdata_o <= ~d;
   endtask : wr

   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask : wr16

   // Data is taken one cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      sfr_addr_o <= a;
      sfr_rd_o   <= 1'b1;
      @(posedge core_clk_i);
      sfr_rd_o   <= 1'b0;
      sfr_addr_o <= ~a;
      @(posedge core_clk_i);
      #1;
      d = sfr_rdata_i;
   endtask : rd
endmodule : capw_cpu_model
`default_nettype wire
